// ==== tpc_afifo.sv ====
module tpc_afifo #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 32
) (
   // write side
   input  wire logic             wr_clk_in,
   input  wire logic             wr_resetn_in,
   input  wire logic             wr_valid_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   output logic                  wr_ready_out,
   // read side
   input  wire logic             rd_clk_in,
   input  wire logic             rd_resetn_in,
   output logic                  rd_valid_out,
   output logic      [WIDTH-1:0] rd_data_out,
   input  wire logic             rd_ready_in
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wbin_ff, wgray_ff, wq1_ff, wq2_ff, nxt_wbin;
   logic [AW:0]      rbin_ff, rgray_ff, rq1_ff, rq2_ff, nxt_rbin;

   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction

   // ==========================================
   // write domain
   assign wr_ready_out = (wgray_ff != {~rq2_ff[AW:AW-1], rq2_ff[AW-2:0]});
   assign nxt_wbin     = wbin_ff + {{AW{1'b0}}, wr_valid_in & wr_ready_out};

   always_ff @(posedge wr_clk_in or negedge wr_resetn_in) begin
      if (!wr_resetn_in) begin
         wbin_ff  <= '0;
         wgray_ff <= '0;
         rq1_ff   <= '0;
         rq2_ff   <= '0;
      end else begin
         wbin_ff  <= nxt_wbin;
         wgray_ff <= to_gray(nxt_wbin);
         rq1_ff   <= rgray_ff;
         rq2_ff   <= rq1_ff;
      end
   end

   always_ff @(posedge wr_clk_in) begin
      if (wr_valid_in && wr_ready_out) begin
         mem[wbin_ff[AW-1:0]] <= wr_data_in;
      end
   end

   // ==========================================
   // read domain
   assign rd_valid_out = (rgray_ff != wq2_ff);
   assign rd_data_out  = mem[rbin_ff[AW-1:0]];
   assign nxt_rbin     = rbin_ff + {{AW{1'b0}}, rd_valid_out & rd_ready_in};

   always_ff @(posedge rd_clk_in or negedge rd_resetn_in) begin
      if (!rd_resetn_in) begin
         rbin_ff  <= '0;
         rgray_ff <= '0;
         wq1_ff   <= '0;
         wq2_ff   <= '0;
      end else begin
         rbin_ff  <= nxt_rbin;
         rgray_ff <= to_gray(nxt_rbin);
         wq1_ff   <= wgray_ff;
         wq2_ff   <= wq1_ff;
      end
   end
endmodule

// ==== tpc_link_host_model.sv ====
// ==========
// host serialiser: free-running link, idle words when nothing queued
module tpc_link_host_model (
   input  logic       link_clk_in,
   output logic [2:0] lane_out,
   output logic       lane_clk_out
);
   timeunit 1ns;
   timeprecision 1ns;
   tpc_pkg::tpc_word_s q [$];
   logic [20:0]        cur;
   initial begin
      lane_out = 3'h0;
      lane_clk_out = 1'b0;
      forever begin
         cur = (q.size() != 0) ? q.pop_front() : 21'h0;
         for (int k = 0; k < 7; k++) begin
            @(negedge link_clk_in);
            lane_clk_out <= (k < 3);
            lane_out <= {cur[14+k], cur[7+k], cur[k]};
         end
      end
   end
endmodule

// ==== tpc_lvds_rx.sv ====
module tpc_lvds_rx (
   // link clock and reset
   input  wire logic          link_clk_in,
   input  wire logic          resetn_in,
   // serial lanes, lsb first
   input  wire logic [2:0]    lane_in,
   input  wire logic          lane_clk_in,
   // parallel words
   output tpc_pkg::tpc_word_s word_out,
   output logic               word_valid_out,
   output logic               link_resetn_out
);
   logic [1:0]                                   rst_ff;
   logic [tpc_pkg::SER_BITS-1:0]                 shift_ff [tpc_pkg::LANES];
   logic [tpc_pkg::LANES*tpc_pkg::SER_BITS-1:0] frame;
   logic                                         clk_prev_ff;
   logic                                         primed_ff;
   logic                                         boundary;

   // reset asserts at once and leaves on the link clock
   always_ff @(posedge link_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_ff <= 2'h0;
      end else begin
         rst_ff <= {rst_ff[0], 1'b1};
      end
   end
   assign link_resetn_out = rst_ff[1];

   genvar g;
   generate
      for (g = 0; g < tpc_pkg::LANES; g++) begin : g_lane
         always_ff @(posedge link_clk_in) begin
            shift_ff[g] <= {lane_in[g], shift_ff[g][tpc_pkg::SER_BITS-1:1]};
         end
         assign frame[g*tpc_pkg::SER_BITS +: tpc_pkg::SER_BITS] = shift_ff[g];
      end
   endgenerate

   // the clock lane rises once per word; the first word after reset is partial
   assign boundary = lane_clk_in & ~clk_prev_ff;

   always_ff @(posedge link_clk_in or negedge link_resetn_out) begin
      if (!link_resetn_out) begin
         clk_prev_ff    <= 1'b0;
         primed_ff      <= 1'b0;
         word_valid_out <= 1'b0;
         word_out       <= '0;
      end else begin
         clk_prev_ff    <= lane_clk_in;
         primed_ff      <= primed_ff | boundary;
         word_valid_out <= boundary & primed_ff;
         if (boundary) begin
            word_out <= tpc_pkg::tpc_word_s'(frame);
         end
      end
   end
endmodule

// ==== tpc_pkg.sv ====
package tpc_pkg;
   // ==========================================
   // data widths
   localparam int PIX_W      = 18;
   localparam int LANES      = 3;
   localparam int SER_BITS   = 7;
   localparam int FIFO_DEPTH = 32;
   localparam int POL_LIMIT  = 18;
   // ==========================================
   // timing
   localparam int REF_CLK_KHZ  = 25000;
   localparam int LOCK_TIME_MS = 1;
   localparam int LOCK_CYC_DEF = LOCK_TIME_MS * REF_CLK_KHZ;
   localparam int LOCK_CNT_W   = 16;
   // ==========================================
   // reset values, pins {sel_b, sel_a, linv_en, pol_en, shutdown_n}
   localparam logic [4:0] CFG_RST = 5'h08;
   localparam int CFG_SD   = 0;
   localparam int CFG_POL  = 1;
   localparam int CFG_LINV = 2;
   localparam int CFG_SELA = 3;
   localparam int CFG_SELB = 4;
   // ==========================================
   // carriers
   typedef struct packed {
      logic             vsync;
      logic             hsync;
      logic             de;
      logic [PIX_W-1:0] pix;
   } tpc_word_s;
   localparam int WORD_W = $bits(tpc_word_s);
   typedef struct packed {
      logic [PIX_W-1:0] odd;
      logic [PIX_W-1:0] even;
   } tpc_pair_s;
   localparam int BUS_W = $bits(tpc_pair_s);
   typedef struct packed {
      logic [3:0] latch_w;
      logic [3:0] gap_w;
      logic [3:0] oe_w;
   } tpc_prof_s;
   // driver strobe profiles, index {sel_b, sel_a}, widths in ref clocks
   localparam tpc_prof_s PROF_TBL [4] = '{'{4'h3, 4'h1, 4'h5}, '{4'h5, 4'h2, 4'h7},
                                          '{4'h2, 4'h1, 4'h3}, '{4'h7, 4'h3, 4'h9}};
endpackage

// ==== tpc_timing_ctrl.sv ====
module tpc_timing_ctrl #(
   parameter int LOCK_CYC = tpc_pkg::LOCK_CYC_DEF
) (
   // clocks and reset
   input  wire logic                      ref_clk_in,
   input  wire logic                      resetn_in,
   input  wire logic                      link_clk_in,
   // serial link
   input  wire logic [2:0]                lane_in,
   input  wire logic                      lane_clk_in,
   output logic                           link_ready_out,
   // option pins
   input  wire logic                      shutdown_n_in,
   input  wire logic                      polarity_reverse_en_in,
   input  wire logic                      line_invert_en_in,
   input  wire logic                      timing_select_a_in,
   input  wire logic                      timing_select_b_in,
   // column drivers
   output logic [tpc_pkg::PIX_W-1:0]      odd_data_out,
   output logic [tpc_pkg::PIX_W-1:0]      even_data_out,
   output logic                           data_pol_out,
   output logic                           odd_hclock_out,
   output logic                           even_hclock_out,
   output logic                           odd_hstart_pulse_out,
   output logic                           even_hstart_pulse_out,
   output logic                           col_latch_strobe_out,
   output logic                           col_output_enable_strobe_out,
   output logic                           odd_line_invert_out,
   output logic                           even_line_invert_out,
   // gate drivers
   output logic                           gate_clock_out,
   output logic                           vertical_start_pulse_out,
   output logic                           gate_enable_a_out,
   output logic                           gate_enable_b_out,
   // status
   output logic                           locked_out,
   output logic                           video_valid_out
);
   typedef enum {SQ_IDLE, SQ_LATCH, SQ_GAP, SQ_OE} tpc_seq_e;

   tpc_pkg::tpc_word_s               rx_word, rd_word;
   tpc_pkg::tpc_pair_s               pair_ff, cand;
   tpc_pkg::tpc_prof_s               prof;
   tpc_seq_e                         seq_ff;
   logic                             rx_valid, link_resetn;
   logic                             rd_valid, rd_ready, take;
   logic [4:0]                       cfg_meta_ff, cfg_ff;
   logic [tpc_pkg::LOCK_CNT_W-1:0]   lock_cnt_ff;
   logic                             locked_ff, blank_ff;
   logic                             de_prev_ff, vs_prev_ff;
   logic                             line_start, line_stop, frame_start;
   logic                             have_odd_ff, pair_rdy_ff, start_req_ff, line_end_ff;
   logic                             phase_ff, issue, issue_start, issue_pair;
   logic                             hclk_ff, sp_ff, pol_ff;
   logic [tpc_pkg::BUS_W-1:0]        bus_ff;
   logic                             inv_ff;
   logic [3:0]                       seq_cnt_ff;
   logic                             seq_start, seq_done, stv_ff;

   // ==========================================
   // link side: deserialiser and crossing buffer
   tpc_lvds_rx u_rx (
      .link_clk_in     (link_clk_in),
      .resetn_in       (resetn_in),
      .lane_in         (lane_in),
      .lane_clk_in     (lane_clk_in),
      .word_out        (rx_word),
      .word_valid_out  (rx_valid),
      .link_resetn_out (link_resetn)
   );

   // the link cannot stall, so a full buffer drops words and shows it here
   tpc_afifo #(
      .WIDTH (tpc_pkg::WORD_W),
      .DEPTH (tpc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .wr_clk_in    (link_clk_in),
      .wr_resetn_in (link_resetn),
      .wr_valid_in  (rx_valid),
      .wr_data_in   (rx_word),
      .wr_ready_out (link_ready_out),
      .rd_clk_in    (ref_clk_in),
      .rd_resetn_in (resetn_in),
      .rd_valid_out (rd_valid),
      .rd_data_out  (rd_word),
      .rd_ready_in  (rd_ready)
   );

   // ==========================================
   // option pins and lock
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cfg_meta_ff <= tpc_pkg::CFG_RST;
         cfg_ff      <= tpc_pkg::CFG_RST;
      end else begin
         cfg_meta_ff <= {timing_select_b_in, timing_select_a_in, line_invert_en_in,
                         polarity_reverse_en_in, shutdown_n_in};
         cfg_ff      <= cfg_meta_ff;
      end
   end

   assign prof = tpc_pkg::PROF_TBL[{cfg_ff[tpc_pkg::CFG_SELB], cfg_ff[tpc_pkg::CFG_SELA]}];

   // shutdown drops lock three clocks after the pin, well inside the off time
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         lock_cnt_ff <= '0;
         locked_ff   <= 1'b0;
      end else if (!cfg_ff[tpc_pkg::CFG_SD]) begin
         lock_cnt_ff <= '0;
         locked_ff   <= 1'b0;
      end else if (!locked_ff) begin
         lock_cnt_ff <= lock_cnt_ff + 16'h0001;
         locked_ff   <= (lock_cnt_ff == tpc_pkg::LOCK_CNT_W'(LOCK_CYC - 1));
      end
   end

   // ==========================================
   // reference points
   // before lock the buffer is drained and its contents thrown away
   assign rd_ready = !locked_ff || (!pair_rdy_ff && !line_end_ff && seq_ff == SQ_IDLE);
   assign take     = rd_valid && rd_ready;
   assign line_start  = take && locked_ff && rd_word.de && !de_prev_ff;
   assign line_stop   = take && locked_ff && !rd_word.de && de_prev_ff;
   assign frame_start = take && locked_ff && rd_word.vsync && !vs_prev_ff;

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         de_prev_ff <= 1'b0;
         vs_prev_ff <= 1'b0;
      end else if (!locked_ff) begin
         de_prev_ff <= 1'b0;
         vs_prev_ff <= 1'b0;
      end else if (take) begin
         de_prev_ff <= rd_word.de;
         vs_prev_ff <= rd_word.vsync;
      end
   end

   // blanked from reset or loss of lock until a frame begins
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         blank_ff <= 1'b1;
      end else if (!locked_ff) begin
         blank_ff <= 1'b1;
      end else if (frame_start) begin
         blank_ff <= 1'b0;
      end
   end

   // ==========================================
   // pixel pairing
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pair_ff     <= '0;
         have_odd_ff <= 1'b0;
         pair_rdy_ff <= 1'b0;
      end else if (!locked_ff) begin
         have_odd_ff <= 1'b0;
         pair_rdy_ff <= 1'b0;
      end else if (take && rd_word.de) begin
         if (!have_odd_ff) begin
            pair_ff.odd <= rd_word.pix;
            have_odd_ff <= 1'b1;
         end else begin
            pair_ff.even <= rd_word.pix;
            have_odd_ff  <= 1'b0;
            pair_rdy_ff  <= 1'b1;
         end
      end else if (line_stop && have_odd_ff) begin
         pair_ff.even <= '0;
         have_odd_ff  <= 1'b0;
         pair_rdy_ff  <= 1'b1;
      end else if (issue_pair) begin
         pair_rdy_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         start_req_ff <= 1'b0;
         line_end_ff  <= 1'b0;
      end else if (!locked_ff) begin
         start_req_ff <= 1'b0;
         line_end_ff  <= 1'b0;
      end else begin
         start_req_ff <= line_start | (start_req_ff & ~issue_start);
         line_end_ff  <= line_stop | (line_end_ff & ~seq_start);
      end
   end

   // ==========================================
   // output slots: two clocks each, clock high in the second
   assign issue       = locked_ff && !phase_ff && (start_req_ff || pair_rdy_ff);
   assign issue_start = issue && start_req_ff;
   assign issue_pair  = issue && !start_req_ff;
   assign cand        = blank_ff ? '0 : pair_ff;

   function automatic int unsigned count_ones(input logic [tpc_pkg::BUS_W-1:0] v);
      int unsigned n;
      n = 0;
      for (int i = 0; i < tpc_pkg::BUS_W; i++) begin
         n += v[i];
      end
      return n;
   endfunction

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         phase_ff <= 1'b0;
         hclk_ff  <= 1'b0;
         sp_ff    <= 1'b0;
      end else if (!locked_ff) begin
         phase_ff <= 1'b0;
         hclk_ff  <= 1'b0;
         sp_ff    <= 1'b0;
      end else begin
         phase_ff <= issue;
         hclk_ff  <= phase_ff;
         if (issue_start) begin
            sp_ff <= 1'b1;
         end else if (hclk_ff) begin
            sp_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         bus_ff <= '0;
         pol_ff <= 1'b0;
      end else if (!locked_ff) begin
         bus_ff <= '0;
         pol_ff <= 1'b0;
      end else if (issue_pair) begin
         if (cfg_ff[tpc_pkg::CFG_POL] && count_ones(cand ^ bus_ff) > tpc_pkg::POL_LIMIT) begin
            bus_ff <= ~cand;
            pol_ff <= 1'b1;
         end else begin
            bus_ff <= cand;
            pol_ff <= 1'b0;
         end
      end
   end

   assign odd_data_out          = bus_ff[tpc_pkg::BUS_W-1 -: tpc_pkg::PIX_W];
   assign even_data_out         = bus_ff[tpc_pkg::PIX_W-1:0];
   assign data_pol_out          = pol_ff;
   assign odd_hclock_out        = hclk_ff;
   assign even_hclock_out       = hclk_ff;
   assign odd_hstart_pulse_out  = sp_ff;
   assign even_hstart_pulse_out = sp_ff;

   // ==========================================
   // line end: latch, gate clock, output enable
   assign seq_start = locked_ff && line_end_ff && !pair_rdy_ff && !phase_ff && seq_ff == SQ_IDLE;
   assign seq_done  = (seq_cnt_ff == 4'h1);

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         seq_ff     <= SQ_IDLE;
         seq_cnt_ff <= 4'h0;
      end else if (!locked_ff) begin
         seq_ff     <= SQ_IDLE;
         seq_cnt_ff <= 4'h0;
      end else begin
         unique case (seq_ff)
            SQ_IDLE: begin
               if (seq_start) begin
                  seq_ff     <= SQ_LATCH;
                  seq_cnt_ff <= prof.latch_w;
               end
            end
            SQ_LATCH: begin
               seq_cnt_ff <= seq_cnt_ff - 4'h1;
               if (seq_done) begin
                  seq_ff     <= SQ_GAP;
                  seq_cnt_ff <= prof.gap_w;
               end
            end
            SQ_GAP: begin
               seq_cnt_ff <= seq_cnt_ff - 4'h1;
               if (seq_done) begin
                  seq_ff     <= SQ_OE;
                  seq_cnt_ff <= prof.oe_w;
               end
            end
            SQ_OE: begin
               seq_cnt_ff <= seq_cnt_ff - 4'h1;
               if (seq_done) begin
                  seq_ff <= SQ_IDLE;
               end
            end
         endcase
      end
   end

   // a frame start raised while its line is still ending wins over the clear
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         stv_ff <= 1'b0;
      end else if (!locked_ff) begin
         stv_ff <= 1'b0;
      end else if (frame_start) begin
         stv_ff <= 1'b1;
      end else if (seq_ff == SQ_OE && seq_done) begin
         stv_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         col_latch_strobe_out         <= 1'b0;
         col_output_enable_strobe_out <= 1'b0;
         gate_clock_out               <= 1'b0;
         gate_enable_a_out            <= 1'b0;
         gate_enable_b_out            <= 1'b0;
         vertical_start_pulse_out     <= 1'b0;
      end else begin
         col_latch_strobe_out         <= locked_ff && seq_ff == SQ_LATCH;
         col_output_enable_strobe_out <= locked_ff && seq_ff == SQ_OE;
         gate_clock_out               <= locked_ff && (seq_ff == SQ_LATCH || seq_ff == SQ_GAP);
         gate_enable_a_out            <= locked_ff && !blank_ff && seq_ff != SQ_LATCH && seq_ff != SQ_GAP;
         gate_enable_b_out            <= locked_ff && !blank_ff && seq_ff != SQ_GAP && seq_ff != SQ_OE;
         vertical_start_pulse_out     <= locked_ff && stv_ff;
      end
   end

   // ==========================================
   // line inversion, flipped at each line end
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         inv_ff <= 1'b0;
      end else if (!locked_ff) begin
         inv_ff <= 1'b0;
      end else if (seq_start) begin
         inv_ff <= ~inv_ff;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         odd_line_invert_out  <= 1'b0;
         even_line_invert_out <= 1'b0;
      end else begin
         odd_line_invert_out  <= locked_ff && cfg_ff[tpc_pkg::CFG_LINV] && inv_ff;
         even_line_invert_out <= locked_ff && cfg_ff[tpc_pkg::CFG_LINV] && !inv_ff;
      end
   end

   // ==========================================
   // status
   assign locked_out      = locked_ff;
   assign video_valid_out = !blank_ff;
endmodule

// ==== tpc_timing_ctrl_assertions.sv ====
// ==========
// pin-level checks on the timing controller
module tpc_timing_ctrl_checker #(
   parameter int LOCK_CYC = 20
) (
   // clock, reset, pins
   input logic                      ref_clk_in,
   input logic                      resetn_in,
   input logic                      shutdown_n_in,
   // outputs watched
   input logic                      locked_out,
   input logic                      video_valid_out,
   input logic [tpc_pkg::PIX_W-1:0] odd_data_out,
   input logic [tpc_pkg::PIX_W-1:0] even_data_out,
   input logic                      odd_hclock_out,
   input logic                      even_hclock_out,
   input logic                      odd_hstart_pulse_out,
   input logic                      even_hstart_pulse_out,
   input logic                      col_latch_strobe_out,
   input logic                      odd_line_invert_out,
   input logic                      even_line_invert_out,
   input logic                      gate_clock_out,
   input logic                      gate_enable_a_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   // raw pin count, so it always runs ahead of the synced lock timer
   logic [15:0] hi_ff;
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) hi_ff <= '0;
      else if (!shutdown_n_in) hi_ff <= '0;
      else if (hi_ff != 16'hffff) hi_ff <= hi_ff + 16'h1;
   end
   sequence s_start_slot;
      odd_hstart_pulse_out && odd_hclock_out ##1 !odd_hstart_pulse_out;
   endsequence
   chk_pins_paired: assert property (odd_hclock_out == even_hclock_out && odd_hstart_pulse_out == even_hstart_pulse_out)
      else $error("odd and even pins differ");
   chk_hclock_pulse: assert property (odd_hclock_out |=> !odd_hclock_out)
      else $error("output clock high too long");
   chk_start_lead: assert property ($rose(odd_hstart_pulse_out) |=> s_start_slot)
      else $error("start pulse not one clock ahead");
   chk_data_slot: assert property (locked_out && ($changed(odd_data_out) || $changed(even_data_out)) |=> odd_hclock_out)
      else $error("bus changed outside a slot");
   chk_unlock_quiet: assert property ($fell(locked_out) |=> !odd_hclock_out && !gate_clock_out && odd_data_out == '0)
      else $error("outputs live after shutdown");
   chk_shutdown_off: assert property (!shutdown_n_in [*4] |-> !locked_out)
      else $error("still locked in shutdown");
   chk_lock_wait: assert property ($rose(locked_out) |-> hi_ff >= LOCK_CYC)
      else $error("locked too early");
   chk_blank_zero: assert property (!video_valid_out |-> odd_data_out == '0 && even_data_out == '0)
      else $error("data while blanked");
   chk_latch_gate: assert property (col_latch_strobe_out |-> gate_clock_out && !gate_enable_a_out)
      else $error("latch without gate clock");
   chk_line_inv_opp: assert property (!(odd_line_invert_out && even_line_invert_out))
      else $error("inversion pins both high");
endmodule
bind tpc_timing_ctrl tpc_timing_ctrl_checker #(.LOCK_CYC(LOCK_CYC)) chk_u (.ref_clk_in, .resetn_in, .shutdown_n_in,
   .locked_out, .video_valid_out, .odd_data_out, .even_data_out, .odd_hclock_out, .even_hclock_out,
   .odd_hstart_pulse_out, .even_hstart_pulse_out, .col_latch_strobe_out, .odd_line_invert_out,
   .even_line_invert_out, .gate_clock_out, .gate_enable_a_out);

// ==== tpc_timing_ctrl_tb_top.sv ====
module tpc_timing_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LOCK = 20;
   localparam int LAT [4] = '{3, 5, 2, 7};
   localparam int OEW [4] = '{5, 7, 3, 9};
   logic ref_clk_in = 0, link_clk_in = 0, resetn_in = 0, shutdown_n_in = 0, polarity_reverse_en_in = 0;
   logic line_invert_en_in = 0, timing_select_a_in = 1, timing_select_b_in = 0, lane_clk_in, link_ready_out;
   logic [2:0] lane_in;
   logic [17:0] odd_data_out, even_data_out;
   logic data_pol_out, odd_hclock_out, even_hclock_out, odd_hstart_pulse_out, even_hstart_pulse_out;
   logic col_latch_strobe_out, col_output_enable_strobe_out, odd_line_invert_out, even_line_invert_out;
   logic gate_clock_out, vertical_start_pulse_out, gate_enable_a_out, gate_enable_b_out, locked_out, video_valid_out;
   logic [36:0] got_q [$];
   logic [35:0] prev = '0;
   int failures = 0, total_checks = 0, lat_n = 0, lat_w = 0, oe_n = 0, oe_w = 0, lines = 0, vsp_n = 0;
   tpc_timing_ctrl #(.LOCK_CYC(LOCK)) dut_u (.*);
   tpc_link_host_model link_u (.link_clk_in, .lane_out(lane_in), .lane_clk_out(lane_clk_in));
   initial forever #20 ref_clk_in = ~ref_clk_in;
   initial begin
      #7;
      forever #40 link_clk_in = ~link_clk_in;
   end
   // ==========
   // monitor: pairs at data slots, strobe widths, line count
   always @(negedge ref_clk_in) begin
      if (odd_hclock_out && !odd_hstart_pulse_out) got_q.push_back({data_pol_out, odd_data_out, even_data_out});
      lat_n <= col_latch_strobe_out ? lat_n + 1 : 0;
      if (!col_latch_strobe_out && lat_n != 0) lat_w <= lat_n;
      oe_n <= col_output_enable_strobe_out ? oe_n + 1 : 0;
      if (!col_output_enable_strobe_out && oe_n != 0) lines <= lines + 1;
      if (!col_output_enable_strobe_out && oe_n != 0) oe_w <= oe_n;
      if (vertical_start_pulse_out) vsp_n <= vsp_n + 1;
   end
   task automatic chk(input logic [36:0] got, input logic [36:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [36:0] enc(input logic [35:0] w, input bit pe);
      return (pe && $countones(w ^ prev) > 18) ? {1'b1, ~w} : {1'b0, w};
   endfunction
   task automatic results;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ==========
   // scenarios
   task automatic t_lock;
      shutdown_n_in = 1;
      repeat (LOCK) @(negedge ref_clk_in);
      chk(37'(locked_out), 37'h0);
      repeat (6) @(negedge ref_clk_in);
      chk(37'(locked_out), 37'h1);
      $display("lock done");
   endtask
   task automatic t_frame;
      chk(37'(video_valid_out), 37'h0);
      link_u.q.push_back(21'h100000);
      for (int i = 0; i < 200 && !video_valid_out; i++) @(negedge ref_clk_in);
      chk(37'(video_valid_out), 37'h1);
      // the start pulse pin lags unblanking by a clock, the count by half a clock more
      repeat (3) @(negedge ref_clk_in);
      chk(37'(vsp_n != 0), 37'h1);
      $display("frame done");
   endtask
   task automatic run_line(input logic [53:0] px, input int sel, input bit pe);
      logic [36:0] e;
      int          l0;
      logic        inv0;
      {timing_select_b_in, timing_select_a_in} = 2'(sel);
      polarity_reverse_en_in = pe;
      line_invert_en_in = (sel != 0);
      repeat (4) @(negedge ref_clk_in);
      got_q.delete();
      l0 = lines;
      inv0 = odd_line_invert_out;
      for (int i = 2; i >= 0; i--) link_u.q.push_back({3'b001, px[18*i +: 18]});
      for (int i = 0; i < 600 && lines == l0; i++) @(negedge ref_clk_in);
      chk(37'(lines), 37'(l0 + 1));
      chk(37'(lat_w), 37'(LAT[sel]));
      chk(37'(oe_w), 37'(OEW[sel]));
      chk(37'(got_q.size()), 37'h2);
      e = enc(px[53:18], pe);
      chk(got_q[0], e);
      prev = e[35:0];
      e = enc({px[17:0], 18'h0}, pe);
      chk(got_q[1], e);
      prev = e[35:0];
      chk(37'({odd_line_invert_out, even_line_invert_out}), 37'((sel != 0) ? {~inv0, inv0} : 2'b00));
      chk(37'({gate_enable_a_out, gate_enable_b_out}), 37'h3);
      chk(37'(link_ready_out), 37'h1);
   endtask
   task automatic t_lines;
      run_line({18'h12345, 18'h00000, 18'h3ffff}, 0, 0);
      run_line({18'h00000, 18'h3ffff, 18'h3ffff}, 1, 1);
      run_line({18'h3fe00, 18'h001ff, 18'h00000}, 2, 1);
      run_line({18'h3ffff, 18'h3ffff, 18'h00001}, 3, 0);
      $display("lines done");
   endtask
   task automatic t_shut;
      shutdown_n_in = 0;
      repeat (6) @(negedge ref_clk_in);
      chk(37'({locked_out, gate_clock_out, odd_hclock_out, odd_data_out}), 37'h0);
      $display("shutdown done");
   endtask
   initial begin
      #300000;
      failures++;
      results();
   end
   initial begin
      repeat (4) @(negedge ref_clk_in);
      resetn_in = 1; // held 4 clocks here; the design needs one edge
      t_lock();
      t_frame();
      t_lines();
      t_shut();
      results();
   end
endmodule
